/* logic/fcs_pkg.sv */
// Summary of operation
// - two-bit source select, resets to external
// - 00/11 base rate: loop timing, clock out
// - 01 base rate: serial clock is input
// - 10 base rate: master PLL, clock out
// - high-speed modes: clock and syncs input
// - base rate sync pins are inputs when bit 4 is set
// - force pattern sends signal loss to line
// - single rail only if LIU single rail
// - loopback 00 is normal operation
// - loopback 10 returns line data via coder
// - loopback 11 re-frames receive payload
// - clock loss falls back to master PLL
package fcs_pkg;

  // ----------------------------------------------------------
  // register indices, byte address is four times the index
  // ----------------------------------------------------------
  localparam logic [15:0] IDX_CLK_SEL  = 16'h0100;
  localparam logic [15:0] IDX_LINE_CTL = 16'h0101;
  localparam logic [15:0] IDX_AUX_CTL  = 16'h0102;
  localparam logic [15:0] IDX_STATUS   = 16'h0103;
  localparam int          ADDR_W       = 16;

  // ----------------------------------------------------------
  // field positions
  // ----------------------------------------------------------
  localparam int CS_LCV     = 7;
  localparam int CS_T1      = 6;
  localparam int CS_SYNC8K  = 5;
  localparam int CS_CLKLOSS = 4;
  localparam int LC_FLOS    = 7;
  localparam int LC_SR      = 6;
  localparam int LC_LB_LO   = 4;
  localparam int LC_ENC     = 1;
  localparam int LC_DEC     = 0;
  localparam int AX_HSPEED  = 0;
  localparam int AX_SYNCINV = 4;
  localparam int AX_LIUSR   = 7;

  // ----------------------------------------------------------
  // reset values
  // ----------------------------------------------------------
  localparam logic [7:0] CLK_SEL_RST  = 8'h11;
  localparam logic [7:0] LINE_CTL_RST = 8'h00;
  localparam logic [7:0] AUX_CTL_RST  = 8'h00;

  // ----------------------------------------------------------
  // encodings
  // ----------------------------------------------------------
  typedef enum logic [1:0] {
    FCS_SRC_LOOP0 = 2'b00,
    FCS_SRC_EXT   = 2'b01,
    FCS_SRC_PLL   = 2'b10,
    FCS_SRC_LOOP3 = 2'b11
  } fcs_src_t;

  typedef enum logic [1:0] {
    FCS_LB_NONE    = 2'b00,
    FCS_LB_LOCAL   = 2'b01,
    FCS_LB_REMOTE  = 2'b10,
    FCS_LB_PAYLOAD = 2'b11
  } fcs_lb_t;

  // one two-way pin: level toward the pin and its drive enable
  typedef struct packed {
    logic o;
    logic oe;
  } fcs_pin_t;

endpackage

/* logic/fcs_clock_source_loopback.sv */
// Added by the designer: the APB slave port.
`timescale 1ns/1ps
module fcs_clock_source_loopback (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [15:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              tx_serial_clock_i,
  output fcs_pkg::fcs_pin_t      tx_serial_clock,
  input  wire logic              tx_frame_sync_i,
  output fcs_pkg::fcs_pin_t      tx_frame_sync,
  input  wire logic              tx_multiframe_sync_i,
  output fcs_pkg::fcs_pin_t      tx_multiframe_sync,
  input  wire logic              recovered_clock,
  input  wire logic              pll_clock,
  input  wire logic              recovery_lost,
  input  wire logic              tx_pcm_data,
  input  wire logic              receive_line_data,
  input  wire logic              tx_framer_data,
  input  wire logic              rx_framer_data,
  input  wire logic              rx_payload_data,
  input  wire logic              framer_frame_sync,
  input  wire logic              framer_multiframe_sync,
  output logic                   tx_timing_clock,
  output logic                   tx_timing_edge,
  output logic                   tx_line_data,
  output logic                   rx_pcm_data,
  output logic                   framer_line_data,
  output logic                   single_rail,
  output logic                   encoder_disable,
  output logic                   decoder_disable,
  output logic                   t1_mode,
  output logic                   sync_all_8k,
  output logic                   lcv_insert
);

  // ----------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------
  localparam int NS = 8;
  logic [NS-1:0] raw_in;
  logic [NS-1:0] meta_q;
  logic [NS-1:0] sync_q;
  logic          tsc_s;
  logic          tfs_s;
  logic          tmfs_s;
  logic          rec_s;
  logic          pll_s;
  logic          lost_s;
  logic          pcm_s;
  logic          line_s;

  assign raw_in = {receive_line_data, tx_pcm_data, recovery_lost,
                   pll_clock, recovered_clock, tx_multiframe_sync_i,
                   tx_frame_sync_i, tx_serial_clock_i};

  // every pin input passes two flops; only the second is read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= raw_in;
      sync_q <= meta_q;
    end
  end

  assign tsc_s  = sync_q[0];
  assign tfs_s  = sync_q[1];
  assign tmfs_s = sync_q[2];
  assign rec_s  = sync_q[3];
  assign pll_s  = sync_q[4];
  assign lost_s = sync_q[5];
  assign pcm_s  = sync_q[6];
  assign line_s = sync_q[7];

  // ----------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------
  logic [7:0]  clk_sel_q;
  logic [7:0]  line_ctl_q;
  logic [7:0]  aux_ctl_q;
  logic [7:0]  status_w;
  logic [31:0] prdata_q;
  logic        hit_clk;
  logic        hit_line;
  logic        hit_aux;
  logic        hit_stat;
  logic        hit_any;
  logic        wr_en;
  logic        setup;

  // byte addresses are four times the register index
  always_comb begin
    hit_clk  = 1'b0;
    hit_line = 1'b0;
    hit_aux  = 1'b0;
    hit_stat = 1'b0;
    if (paddr == {fcs_pkg::IDX_CLK_SEL[13:0], 2'b00}) begin
      hit_clk = 1'b1;
    end else if (paddr == {fcs_pkg::IDX_LINE_CTL[13:0], 2'b00}) begin
      hit_line = 1'b1;
    end else if (paddr == {fcs_pkg::IDX_AUX_CTL[13:0], 2'b00}) begin
      hit_aux = 1'b1;
    end else if (paddr == {fcs_pkg::IDX_STATUS[13:0], 2'b00}) begin
      hit_stat = 1'b1;
    end
  end

  assign hit_any = hit_clk | hit_line | hit_aux | hit_stat;
  assign setup   = psel & ~penable;
  // zero wait states; unmapped access answers with an error
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~hit_any;
  assign wr_en   = psel & penable & pwrite;
  assign prdata  = prdata_q;

  // read data captured in the setup cycle, stable for access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (setup && !pwrite) begin
      if (hit_clk) begin
        prdata_q <= {24'h00_0000, clk_sel_q};
      end else if (hit_line) begin
        prdata_q <= {24'h00_0000, line_ctl_q};
      end else if (hit_aux) begin
        prdata_q <= {24'h00_0000, aux_ctl_q};
      end else if (hit_stat) begin
        prdata_q <= {24'h00_0000, status_w};
      end else begin
        prdata_q <= 32'h0000_0000;
      end
    end
  end

  // clock select register; reserved bits stored as written
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_sel_q <= fcs_pkg::CLK_SEL_RST;
    end else if (wr_en && hit_clk) begin
      clk_sel_q <= pwdata[7:0];
    end
  end

  // single rail is refused while the line unit is dual rail
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_ctl_q <= fcs_pkg::LINE_CTL_RST;
    end else if (wr_en && hit_line) begin
      line_ctl_q <= pwdata[7:0];
      line_ctl_q[fcs_pkg::LC_SR] <= pwdata[fcs_pkg::LC_SR]
        & aux_ctl_q[fcs_pkg::AX_LIUSR];
    end else if (!aux_ctl_q[fcs_pkg::AX_LIUSR]) begin
      line_ctl_q[fcs_pkg::LC_SR] <= 1'b0;
    end
  end

  // mode, sync pin direction and line unit rail setting
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      aux_ctl_q <= fcs_pkg::AUX_CTL_RST;
    end else if (wr_en && hit_aux) begin
      aux_ctl_q <= pwdata[7:0];
    end
  end

  // ----------------------------------------------------------
  // decoded controls
  // ----------------------------------------------------------
  fcs_pkg::fcs_src_t src;
  fcs_pkg::fcs_lb_t  lb;
  logic              base_rate;
  logic              loop_sel;
  logic              loss_en;
  logic              flos;

  assign src       = fcs_pkg::fcs_src_t'(clk_sel_q[1:0]);
  assign lb        = fcs_pkg::fcs_lb_t'(
                       line_ctl_q[fcs_pkg::LC_LB_LO +: 2]);
  assign base_rate = ~aux_ctl_q[fcs_pkg::AX_HSPEED];
  assign loss_en   = clk_sel_q[fcs_pkg::CS_CLKLOSS];
  assign flos      = line_ctl_q[fcs_pkg::LC_FLOS];
  assign loop_sel  = (src == fcs_pkg::FCS_SRC_LOOP0) ||
                     (src == fcs_pkg::FCS_SRC_LOOP3);

  // ----------------------------------------------------------
  // transmit timing source
  // ----------------------------------------------------------
  logic fallback_q;
  logic tclk_d;
  logic tclk_q;
  logic tclk_prev_q;

  // fallback holds only while the recovered clock is missing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fallback_q <= 1'b0;
    end else begin
      fallback_q <= loop_sel & loss_en & lost_s;
    end
  end

  // high-speed modes always take the serial clock pin
  always_comb begin
    tclk_d = tsc_s;
    if (!base_rate) begin
      tclk_d = tsc_s;
    end else begin
      case (src)
        fcs_pkg::FCS_SRC_EXT: begin
          tclk_d = tsc_s;
        end
        fcs_pkg::FCS_SRC_PLL: begin
          tclk_d = pll_s;
        end
        default: begin
          tclk_d = fallback_q ? pll_s : rec_s;
        end
      endcase
    end
  end

  // selected clock level and its rising edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tclk_q      <= 1'b0;
      tclk_prev_q <= 1'b0;
    end else begin
      tclk_q      <= tclk_d;
      tclk_prev_q <= tclk_q;
    end
  end

  assign tx_timing_clock = tclk_q;
  assign tx_timing_edge  = tclk_q & ~tclk_prev_q;

  // ----------------------------------------------------------
  // pin directions
  // ----------------------------------------------------------
  logic tsc_oe_q;
  logic sync_oe_q;
  logic fs_q;
  logic mfs_q;

  // direction changes only after the register write settles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tsc_oe_q  <= 1'b0;
      sync_oe_q <= 1'b0;
    end else begin
      tsc_oe_q  <= base_rate &&
                   (src != fcs_pkg::FCS_SRC_EXT);
      sync_oe_q <= base_rate &&
                   !aux_ctl_q[fcs_pkg::AX_SYNCINV];
    end
  end

  // sync levels from the framer, registered toward the pins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fs_q  <= 1'b0;
      mfs_q <= 1'b0;
    end else begin
      fs_q  <= framer_frame_sync;
      mfs_q <= framer_multiframe_sync;
    end
  end

  // whole-struct drives keep one continuous writer per pin
  assign tx_serial_clock    = '{o: tclk_q, oe: tsc_oe_q};
  assign tx_frame_sync      = '{o: fs_q, oe: sync_oe_q};
  assign tx_multiframe_sync = '{o: mfs_q, oe: sync_oe_q};

  // ----------------------------------------------------------
  // data paths and loopbacks
  // ----------------------------------------------------------
  logic txl_d;
  logic rxp_d;
  logic frl_d;
  logic txl_q;
  logic rxp_q;
  logic frl_q;

  // forced loss pattern wins over every loopback
  always_comb begin
    txl_d = tx_framer_data;
    rxp_d = rx_framer_data;
    frl_d = line_s;
    case (lb)
      fcs_pkg::FCS_LB_LOCAL: begin
        txl_d = 1'b1;
        rxp_d = pcm_s;
        frl_d = 1'b0;
      end
      fcs_pkg::FCS_LB_REMOTE: begin
        txl_d = line_s;
      end
      fcs_pkg::FCS_LB_PAYLOAD: begin
        txl_d = rx_payload_data;
      end
      default: begin
        txl_d = tx_framer_data;
      end
    endcase
    if (flos) begin
      txl_d = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txl_q <= 1'b0;
      rxp_q <= 1'b0;
      frl_q <= 1'b0;
    end else begin
      txl_q <= txl_d;
      rxp_q <= rxp_d;
      frl_q <= frl_d;
    end
  end

  assign tx_line_data     = txl_q;
  assign rx_pcm_data      = rxp_q;
  assign framer_line_data = frl_q;

  // ----------------------------------------------------------
  // static controls and line code violation pulse
  // ----------------------------------------------------------
  logic lcv_prev_q;
  logic lcv_q;

  // a rising write of the bit yields exactly one pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lcv_prev_q <= 1'b0;
      lcv_q      <= 1'b0;
    end else begin
      lcv_prev_q <= clk_sel_q[fcs_pkg::CS_LCV];
      lcv_q      <= clk_sel_q[fcs_pkg::CS_LCV] & ~lcv_prev_q;
    end
  end

  assign lcv_insert      = lcv_q;
  assign single_rail     = line_ctl_q[fcs_pkg::LC_SR];
  assign encoder_disable = line_ctl_q[fcs_pkg::LC_ENC];
  assign decoder_disable = line_ctl_q[fcs_pkg::LC_DEC];
  assign t1_mode         = clk_sel_q[fcs_pkg::CS_T1];
  assign sync_all_8k     = clk_sel_q[fcs_pkg::CS_SYNC8K];

  // ----------------------------------------------------------
  // status view of the block's own state
  // ----------------------------------------------------------
  assign status_w = {3'b000, tsc_oe_q, sync_oe_q, lost_s,
                     fallback_q, tclk_q};

endmodule

/* verif/fcs_partner.sv */
`timescale 1ns/1ps
module fcs_partner (
  input  wire fcs_pkg::fcs_pin_t tx_serial_clock,
  input  wire fcs_pkg::fcs_pin_t tx_frame_sync,
  input  wire fcs_pkg::fcs_pin_t tx_multiframe_sync,
  input  wire logic              lose_rec,
  output logic                   tx_serial_clock_i,
  output logic                   tx_frame_sync_i,
  output logic                   tx_multiframe_sync_i,
  output logic                   recovered_clock,
  output logic                   pll_clock,
  output logic                   recovery_lost,
  output logic                   receive_line_data
);
  logic       sclk = 1'b0;
  logic       pll = 1'b0;
  logic       rec = 1'b0;
  logic [7:0] bit_n = 8'h00;
  logic [2:0] rx_n = 3'h0;
  // ----------------------------------------
  // far-side clocks; sclk keeps a fixed phase to pclk, pll and rec drift
  // ----------------------------------------
  initial begin
    #37;
    forever #100 sclk = ~sclk;
  end
  initial begin
    forever #81 pll = ~pll;
  end
  // recovered clock stands still while lost
  initial begin
    #13;
    forever #97 rec = lose_rec ? rec : ~rec;
  end
  always @(posedge sclk) bit_n <= bit_n + 8'h01;
  always @(posedge rec) rx_n <= rx_n + 3'h3;
  // pins resolve to the device when it drives, else to us
  assign tx_serial_clock_i = tx_serial_clock.oe ? tx_serial_clock.o
                                                : sclk;
  assign tx_frame_sync_i = tx_frame_sync.oe ? tx_frame_sync.o
                                            : (bit_n == 8'h00);
  assign tx_multiframe_sync_i = tx_multiframe_sync.oe
    ? tx_multiframe_sync.o : (bit_n[7:1] == 7'h00);
  assign pll_clock = pll;
  assign recovered_clock = rec;
  assign recovery_lost = lose_rec;
  assign receive_line_data = rx_n[1];
endmodule

/* verif/fcs_clock_source_loopback_sva.sv */
`timescale 1ns/1ps
module fcs_chk (
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [15:0]       paddr,
  input wire logic [31:0]       pwdata,
  input wire fcs_pkg::fcs_pin_t tx_serial_clock,
  input wire fcs_pkg::fcs_pin_t tx_frame_sync,
  input wire fcs_pkg::fcs_pin_t tx_multiframe_sync,
  input wire logic              pll_clock,
  input wire logic              receive_line_data,
  input wire logic              rx_payload_data,
  input wire logic              tx_timing_clock,
  input wire logic              tx_line_data,
  input wire logic              framer_line_data,
  input wire logic              tx_pcm_data,
  input wire logic              rx_pcm_data
);
  localparam logic [15:0] A_CS = fcs_pkg::IDX_CLK_SEL << 2;
  localparam logic [15:0] A_LC = fcs_pkg::IDX_LINE_CTL << 2;
  localparam logic [15:0] A_AX = fcs_pkg::IDX_AUX_CTL << 2;
  logic [1:0] src_q;
  logic [7:0] lc_q;
  logic [7:0] ax_q;
  logic       hs;
  logic       fl;
  logic [1:0] lb;
  logic       run_q;
  assign hs = ax_q[0];
  assign fl = lc_q[7];
  assign lb = lc_q[5:4];
  // sync pins turn to outputs one edge after reset lets go
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) run_q <= 1'b0;
    else run_q <= 1'b1;
  end
  // ----------------------------------------
  // shadow of the control fields
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_q <= fcs_pkg::CLK_SEL_RST[1:0];
      lc_q  <= 8'h00;
      ax_q  <= 8'h00;
    end else if (psel && penable && pwrite) begin
      if (paddr == A_CS) src_q <= pwdata[1:0];
      if (paddr == A_LC) lc_q <= pwdata[7:0];
      if (paddr == A_AX) ax_q <= pwdata[7:0];
    end
  end
  // ----------------------------------------
  // pin direction and line path
  // ----------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // two samples: pins lag the register write by one edge
  property p_drv;
    (!hs && src_q != 2'b01) [*2] |-> tx_serial_clock.oe;
  endproperty
  a_drv: assert property (p_drv) else $error("clock oe low");
  property p_ext;
    (hs || src_q == 2'b01) [*2] |-> !tx_serial_clock.oe;
  endproperty
  a_ext: assert property (p_ext) else $error("clock oe high");
  property p_pll;
    (!hs && src_q == 2'b10) [*2] |-> tx_timing_clock == $past(pll_clock, 3);
  endproperty
  a_pll: assert property (p_pll) else $error("timing not pll");
  property p_sin;
    (hs || ax_q[4]) [*2] |-> !tx_frame_sync.oe && !tx_multiframe_sync.oe;
  endproperty
  a_sin: assert property (p_sin) else $error("sync driven");
  property p_sout;
    (run_q && !hs && !ax_q[4]) [*2] |->
      tx_frame_sync.oe && tx_multiframe_sync.oe;
  endproperty
  a_sout: assert property (p_sout) else $error("sync not driven");
  property p_los;
    fl [*2] |-> !tx_line_data;
  endproperty
  a_los: assert property (p_los) else $error("loss pattern");
  property p_loc;
    (lb == 2'b01 && !fl) [*2] |-> tx_line_data && !framer_line_data;
  endproperty
  a_loc: assert property (p_loc) else $error("local loop");
  property p_lpcm;
    (lb == 2'b01) [*2] |-> rx_pcm_data == $past(tx_pcm_data, 3);
  endproperty
  a_lpcm: assert property (p_lpcm) else $error("local pcm loop");
  property p_rem;
    (lb == 2'b10 && !fl) [*2] |-> tx_line_data == $past(receive_line_data, 3);
  endproperty
  a_rem: assert property (p_rem) else $error("remote loop");
  property p_pay;
    (lb == 2'b11 && !fl) [*2] |-> tx_line_data == $past(rx_payload_data);
  endproperty
  a_pay: assert property (p_pay) else $error("payload loop");
  c_pll: cover property (src_q == 2'b10 && tx_serial_clock.oe);
  c_hs: cover property (hs && !tx_frame_sync.oe);
  c_loc: cover property (lb == 2'b01 && tx_line_data);
endmodule
bind fcs_clock_source_loopback fcs_chk u_chk (.*);

/* verif/test_framer_clock_source_and_loopback.sv */
`timescale 1ns/1ps
module test_framer_clock_source_and_loopback;
  localparam logic [15:0] A_CS = fcs_pkg::IDX_CLK_SEL << 2;
  localparam logic [15:0] A_LC = fcs_pkg::IDX_LINE_CTL << 2;
  localparam logic [15:0] A_AX = fcs_pkg::IDX_AUX_CTL << 2;
  localparam logic [15:0] A_ST = fcs_pkg::IDX_STATUS << 2;
  logic              pclk, presetn, psel, penable, pwrite, pready;
  logic              pslverr, err_q, lose_rec, tx_serial_clock_i;
  logic              tx_frame_sync_i, tx_multiframe_sync_i;
  logic              recovered_clock, pll_clock, recovery_lost;
  logic              tx_pcm_data, receive_line_data, tx_framer_data;
  logic              rx_framer_data, rx_payload_data, framer_frame_sync;
  logic              framer_multiframe_sync, tx_timing_clock;
  logic              tx_timing_edge, tx_line_data, rx_pcm_data;
  logic              framer_line_data, single_rail, encoder_disable;
  logic              decoder_disable, t1_mode, sync_all_8k, lcv_insert;
  logic [15:0]       paddr;
  logic [31:0]       pwdata, prdata, rd_q;
  logic [7:0]        pat;
  fcs_pkg::fcs_pin_t tx_serial_clock, tx_frame_sync, tx_multiframe_sync;
  int                n_fail, checked;

  fcs_clock_source_loopback dut (.*);
  fcs_partner u_far (.*);

  // data inputs keep moving so every path shows
  assign {framer_multiframe_sync, framer_frame_sync, rx_payload_data,
          rx_framer_data, tx_framer_data, tx_pcm_data} = pat[5:0] ^ pat[7:2];
  always @(posedge pclk) pat <= pat + 8'h01;
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  // ----------------------------------------
  // bus cycles and comparison
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  // holds the request until pready is seen high
  task automatic apb(input logic w, input logic [15:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd_q = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [15:0] a, input logic [31:0] e,
                    input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rd_q);
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge pclk);
  endtask
  task automatic end_of_test;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    n_fail = 0;
    checked = 0;
    pat = 8'h00;
    {presetn, psel, penable, pwrite, lose_rec} = 5'h0;
    paddr = 16'h0;
    pwdata = 32'h0;
    tick(16);
    presetn <= 1'b1;
    tick(1);
    rd(A_CS, 32'h11, "clk_sel");
    rd(A_LC, 32'h00, "line_ctl");
    chk("clk_oe", 32'h0, tx_serial_clock.oe);
    chk("sync_oe", 32'h1, tx_frame_sync.oe);
    $display("test reset done");
    for (int s = 0; s < 4; s++) begin
      wr(A_CS, 32'h10 | 32'(s));
      tick(6);
      chk("clk_oe", {31'h0, s != 1}, tx_serial_clock.oe);
    end
    $display("test clock source done");
    wr(A_AX, 32'h01);
    tick(2);
    chk("pins_oe", 32'h0, {tx_serial_clock.oe, tx_frame_sync.oe,
                           tx_multiframe_sync.oe});
    wr(A_AX, 32'h10);
    tick(2);
    chk("sync_oe", 32'h0, {tx_frame_sync.oe, tx_multiframe_sync.oe});
    wr(A_AX, 32'h00);
    tick(2);
    chk("sync_oe", 32'h3, {tx_frame_sync.oe, tx_multiframe_sync.oe});
    $display("test direction done");
    wr(A_LC, 32'h40);
    rd(A_LC, 32'h00, "line_ctl");
    wr(A_AX, 32'h80);
    wr(A_LC, 32'h40);
    rd(A_LC, 32'h40, "line_ctl");
    chk("single_rail", 32'h1, single_rail);
    wr(A_AX, 32'h00);
    rd(A_LC, 32'h00, "line_ctl");
    chk("single_rail", 32'h0, single_rail);
    $display("test single rail done");
    wr(A_LC, 32'h10);
    tick(4);
    chk("line", 32'h1, tx_line_data);
    chk("framer_line", 32'h0, framer_line_data);
    wr(A_LC, 32'h90);
    tick(2);
    chk("line", 32'h0, tx_line_data);
    wr(A_LC, 32'h20);
    tick(20);
    wr(A_LC, 32'h30);
    tick(20);
    wr(A_LC, 32'h00);
    apb(1'b0, 16'h0500, 32'h0);
    chk("unmapped", 32'h0, rd_q);
    chk("slverr", 32'h1, err_q);
    $display("test loopback done");
    wr(A_LC, 32'h03);
    wr(A_CS, 32'hE1);
    tick(1);
    chk("ctl_bits", 32'h1F, {encoder_disable, decoder_disable, t1_mode,
                             sync_all_8k, lcv_insert});
    tick(1);
    chk("lcv", 32'h0, lcv_insert);
    $display("test control bits done");
    // loop source with clock loss protection on
    wr(A_CS, 32'h10);
    lose_rec <= 1'b1;
    tick(8);
    apb(1'b0, A_ST, 32'h0);
    chk("fallback", 32'h2, rd_q & 32'h2);
    lose_rec <= 1'b0;
    tick(8);
    apb(1'b0, A_ST, 32'h0);
    chk("fallback", 32'h0, rd_q & 32'h2);
    $display("test fallback done");
    end_of_test;
  end
  // a hung handshake must still end the run
  initial begin
    #200000;
    n_fail++;
    end_of_test;
  end
endmodule
